/* File: hw/uart_rx_status_params.svh */
// Constants of the receive status block: offsets, fields, resets, sizes
`ifndef UART_RX_STATUS_PARAMS_SVH
`define UART_RX_STATUS_PARAMS_SVH

// ==========================================
// Register byte offsets
`define OFS_STATUS_CONTROL 8'h00
`define OFS_CONFIG 8'h04
`define OFS_BAUD 8'h08
`define OFS_RX_DATA 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_MSB 7

// ==========================================
// Status and control fields, and the address bit of a nine-bit character
`define BIT_ADDR_DET_EN 5
`define BIT_RX_IDLE 4
`define BIT_PAR_ERR 3
`define BIT_FRM_ERR 2
`define BIT_OVR_ERR 1
`define BIT_RXDA 0
`define BIT_ADDR9 8

// ==========================================
// Character format field of the config register
`define MODE_LSB 0
`define MODE_MSB 1
`define MODE_8N 2'h0
`define MODE_8E 2'h1
`define MODE_8O 2'h2
`define MODE_9N 2'h3

// ==========================================
// Interrupt bits
`define IRQ_RX 0
`define IRQ_OVR 1
`define IRQ_ERR 2
`define IRQ_W 3

// ==========================================
// Sizes and reset values
`define DATA_W 9
`define FIFO_DEPTH 4
`define PTR_W 2
`define DIV_W 16
`define BAUD_RST 16'h0010
`define BITS_8 4'h7
`define BITS_9 4'h8
`define ENT_PAR_ERR 9
`define ENT_FRM_ERR 10
`define ENT_W 11

`endif

/* File: hw/uart_rx_status_pkg.sv */
// Types of the receive status block
package uart_rx_status_pkg;

	// ==========================================
	// Receiver sequence
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP = 3'b100
	} rx_state_t;

endpackage

/* File: hw/uart_rx_status.sv */
// Serial receiver with status flags, address detect and AHB-Lite registers
// What this block does
// RL1: Address detect mode acts only when the enable bit is set and nine-bit mode is selected.
// RL2: In address detect mode only characters whose bit 8 is one are kept, as address characters.
// RL3: The idle flag is read-only and reads one only while no character is being received.
// RL4: The parity flag is read-only and shows the parity error of the character at the FIFO head.
// RL5: The framing flag is read-only and shows the framing error of the character at the FIFO head.
// RL6: The overrun flag is set on buffer overflow and software may only clear it, never set it.
// RL7: Clearing a set overrun flag empties the receive buffer and the receive shift register.
// RL8: The data-available flag is read-only and reads one while the buffer holds a character.
// RL9: The error flags follow the FIFO head, so they always describe the next character read.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_status_params.svh"

module uart_rx_status (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Serial line and interrupt
	input wire logic rx_serial,
	output logic irq
);

	// ==========================================
	// Declarations
	uart_rx_status_pkg::rx_state_t st_r, st_nxt;
	logic [`DIV_W-1:0] cnt_r, cnt_nxt, baud_r, baud_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [`DATA_W-1:0] receive_shift_register_r, receive_shift_register_nxt;
	logic par_r, par_nxt;
	logic [`ENT_W-1:0] mem_r [`FIFO_DEPTH];
	logic [`ENT_W-1:0] mem_nxt [`FIFO_DEPTH];
	logic [`PTR_W:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic address_detect_enable_r, address_detect_enable_nxt;
	logic overrun_error_flag_r, overrun_error_flag_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [`IRQ_W-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
	logic wr_ph_r, wr_ph_nxt;
	logic [`OFS_MSB:0] wa_r, wa_nxt;
	logic [31:0] hrdata_nxt;
	logic irq_nxt;
	logic empty, full, nine, parity_on, addr_mode;
	logic done, keep, push, pop, ovr_evt, ovr_clr, flush;
	logic [`DATA_W-1:0] char_val;
	logic par_err_evt, frm_err_evt;
	logic rd_take;
	logic [`OFS_MSB:0] ra;
	logic [`ENT_W-1:0] head;
	logic receiver_idle_flag, parity_error_flag, framing_error_flag, receive_data_available;
	logic [31:0] status_word;

	// ==========================================
	// Decoding
	function automatic logic hit(input logic [`OFS_MSB:0] a, input logic [`OFS_MSB:0] ofs);
		hit = (a == ofs);
	endfunction

	assign empty = (wp_r == rp_r);
	assign full = (wp_r[`PTR_W-1:0] == rp_r[`PTR_W-1:0]) && (wp_r[`PTR_W] != rp_r[`PTR_W]);
	assign nine = (mode_r == `MODE_9N);
	assign parity_on = (mode_r == `MODE_8E) || (mode_r == `MODE_8O);
	assign addr_mode = address_detect_enable_r && nine; // RL1
	assign head = mem_r[rp_r[`PTR_W-1:0]];

	// ==========================================
	// Status flags
	assign receiver_idle_flag = (st_r == uart_rx_status_pkg::RX_IDLE); // RL3
	assign receive_data_available = !empty; // RL8
	// Head entry carries its own errors, so the flags move with each pop
	assign parity_error_flag = !empty && head[`ENT_PAR_ERR]; // RL4 RL9
	assign framing_error_flag = !empty && head[`ENT_FRM_ERR]; // RL5 RL9

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`BIT_ADDR_DET_EN] = address_detect_enable_r;
		status_word[`BIT_RX_IDLE] = receiver_idle_flag;
		status_word[`BIT_PAR_ERR] = parity_error_flag;
		status_word[`BIT_FRM_ERR] = framing_error_flag;
		status_word[`BIT_OVR_ERR] = overrun_error_flag_r;
		status_word[`BIT_RXDA] = receive_data_available;
	end

	// ==========================================
	// AHB-Lite access
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	assign ra = haddr[`OFS_MSB:0];
	assign pop = rd_take && hit(ra, `OFS_RX_DATA) && !empty;
	// Only a one-to-zero change clears; writing one never sets the flag
	assign ovr_clr = wr_ph_r && hit(wa_r, `OFS_STATUS_CONTROL)
		&& overrun_error_flag_r && !hwdata[`BIT_OVR_ERR]; // RL6

	always_comb begin
		wr_ph_nxt = hsel && hready && htrans[1] && hwrite;
		wa_nxt = haddr[`OFS_MSB:0];
		hrdata_nxt = 32'h0000_0000;
		if (rd_take) begin
			unique case (ra)
				`OFS_STATUS_CONTROL: hrdata_nxt = status_word;
				`OFS_CONFIG: hrdata_nxt[`MODE_MSB:`MODE_LSB] = mode_r;
				`OFS_BAUD: hrdata_nxt[`DIV_W-1:0] = baud_r;
				`OFS_RX_DATA: hrdata_nxt[`DATA_W-1:0] = empty ? `DATA_W'h000 : head[`DATA_W-1:0];
				`OFS_IRQ_STATUS: hrdata_nxt[`IRQ_W-1:0] = ist_r;
				`OFS_IRQ_MASK: hrdata_nxt[`IRQ_W-1:0] = imsk_r;
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end
		address_detect_enable_nxt = address_detect_enable_r;
		mode_nxt = mode_r;
		baud_nxt = baud_r;
		imsk_nxt = imsk_r;
		if (wr_ph_r) begin
			if (hit(wa_r, `OFS_STATUS_CONTROL))
				address_detect_enable_nxt = hwdata[`BIT_ADDR_DET_EN];
			if (hit(wa_r, `OFS_CONFIG))
				mode_nxt = hwdata[`MODE_MSB:`MODE_LSB];
			if (hit(wa_r, `OFS_BAUD))
				baud_nxt = hwdata[`DIV_W-1:0];
			if (hit(wa_r, `OFS_IRQ_MASK))
				imsk_nxt = hwdata[`IRQ_W-1:0];
		end
	end

	// ==========================================
	// Receiver sequence
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		bit_nxt = bit_r;
		receive_shift_register_nxt = receive_shift_register_r;
		par_nxt = par_r;
		done = 1'b0;
		par_err_evt = 1'b0;
		frm_err_evt = 1'b0;
		unique case (st_r)
			uart_rx_status_pkg::RX_IDLE: begin
				if (!rx_serial) begin
					st_nxt = uart_rx_status_pkg::RX_START;
					cnt_nxt = baud_r >> 1;
				end
			end
			uart_rx_status_pkg::RX_START: begin
				if (cnt_r != `DIV_W'h0000)
					cnt_nxt = cnt_r - `DIV_W'h0001;
				else if (rx_serial)
					st_nxt = uart_rx_status_pkg::RX_IDLE;
				else begin
					st_nxt = uart_rx_status_pkg::RX_DATA;
					cnt_nxt = baud_r - `DIV_W'h0001;
					bit_nxt = 4'h0;
					par_nxt = (mode_r == `MODE_8O);
				end
			end
			uart_rx_status_pkg::RX_DATA: begin
				if (cnt_r != `DIV_W'h0000)
					cnt_nxt = cnt_r - `DIV_W'h0001;
				else begin
					cnt_nxt = baud_r - `DIV_W'h0001;
					receive_shift_register_nxt = {rx_serial, receive_shift_register_r[`DATA_W-1:1]};
					par_nxt = par_r ^ rx_serial;
					bit_nxt = bit_r + 4'h1;
					if (bit_r == (nine ? `BITS_9 : `BITS_8))
						st_nxt = parity_on ? uart_rx_status_pkg::RX_PARITY
							: uart_rx_status_pkg::RX_STOP;
				end
			end
			uart_rx_status_pkg::RX_PARITY: begin
				if (cnt_r != `DIV_W'h0000)
					cnt_nxt = cnt_r - `DIV_W'h0001;
				else begin
					cnt_nxt = baud_r - `DIV_W'h0001;
					par_nxt = par_r ^ rx_serial;
					st_nxt = uart_rx_status_pkg::RX_STOP;
				end
			end
			uart_rx_status_pkg::RX_STOP: begin
				if (cnt_r != `DIV_W'h0000)
					cnt_nxt = cnt_r - `DIV_W'h0001;
				else begin
					done = 1'b1;
					par_err_evt = parity_on && par_r;
					frm_err_evt = !rx_serial;
					st_nxt = uart_rx_status_pkg::RX_IDLE;
				end
			end
			default: st_nxt = uart_rx_status_pkg::RX_IDLE;
		endcase
		// Clear drops any character in flight; keyed on the write, not on done
		if (ovr_clr) begin
			st_nxt = uart_rx_status_pkg::RX_IDLE;
			receive_shift_register_nxt = `DATA_W'h000; // RL7
		end
	end

	// ==========================================
	// Receive buffer and overrun
	assign char_val = nine ? receive_shift_register_r
		: {1'b0, receive_shift_register_r[`DATA_W-1:1]};
	assign keep = !addr_mode || char_val[`BIT_ADDR9]; // RL2
	// While overrun stands, new characters are dropped until software clears it
	assign ovr_evt = done && keep && (full || overrun_error_flag_r) && !pop; // RL6
	assign push = done && keep && !ovr_evt && !overrun_error_flag_r;
	// Set wins: a fresh overrun in the clearing cycle keeps the flag and the data
	assign flush = ovr_clr && !ovr_evt; // RL7

	always_comb begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (push) begin
			mem_nxt[wp_r[`PTR_W-1:0]] = {frm_err_evt, par_err_evt, char_val};
			wp_nxt = wp_r + 1'b1;
		end
		if (pop)
			rp_nxt = rp_r + 1'b1; // RL9
		if (flush) begin
			wp_nxt = '0; // RL7
			rp_nxt = '0;
		end
		overrun_error_flag_nxt = ovr_evt || (overrun_error_flag_r && !ovr_clr); // RL6
	end

	// ==========================================
	// Interrupts
	always_comb begin
		ist_nxt = ist_r;
		if (wr_ph_r && hit(wa_r, `OFS_IRQ_STATUS))
			ist_nxt = ist_r & ~hwdata[`IRQ_W-1:0];
		if (push)
			ist_nxt[`IRQ_RX] = 1'b1;
		if (ovr_evt)
			ist_nxt[`IRQ_OVR] = 1'b1;
		if (push && (par_err_evt || frm_err_evt))
			ist_nxt[`IRQ_ERR] = 1'b1;
		irq_nxt = |(ist_nxt & imsk_nxt);
	end

	// ==========================================
	// Registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= uart_rx_status_pkg::RX_IDLE;
			cnt_r <= `DIV_W'h0000;
			bit_r <= 4'h0;
			receive_shift_register_r <= `DATA_W'h000;
			par_r <= 1'b0;
			wp_r <= '0;
			rp_r <= '0;
			address_detect_enable_r <= 1'b0;
			overrun_error_flag_r <= 1'b0;
			mode_r <= `MODE_8N;
			baud_r <= `BAUD_RST;
			ist_r <= '0;
			imsk_r <= '0;
			wr_ph_r <= 1'b0;
			wa_r <= '0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			irq <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			receive_shift_register_r <= receive_shift_register_nxt;
			par_r <= par_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			address_detect_enable_r <= address_detect_enable_nxt;
			overrun_error_flag_r <= overrun_error_flag_nxt;
			mode_r <= mode_nxt;
			baud_r <= baud_nxt;
			ist_r <= ist_nxt;
			imsk_r <= imsk_nxt;
			wr_ph_r <= wr_ph_nxt;
			wa_r <= wa_nxt;
			hrdata <= hrdata_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			irq <= irq_nxt;
		end
	end

	// Buffer words carry no reset; pointers decide what is valid
	always_ff @(posedge hclk) begin
		mem_r <= mem_nxt;
	end

endmodule // uart_rx_status

`default_nettype wire

/* File: verification/uart_tx_model.sv */
// Far-end serial transmitter model
`timescale 1ns/100ps
`default_nettype none

module uart_tx_model #(
	parameter int BIT_CYC = 16
) (
	// Clock and line
	input wire logic hclk,
	output logic rx_serial
);
	initial rx_serial = 1'b1;

	// ==========
	// Frame sender
	task automatic bit_out(input logic b);
		@(posedge hclk);
		rx_serial <= b;
		repeat (BIT_CYC - 1) @(posedge hclk);
	endtask

	// Negative pbit sends no parity
	task automatic send(input logic [8:0] d, input int nb, input int pbit, input logic stop);
		bit_out(1'b0);
		for (int i = 0; i < nb; i++) bit_out(d[i]);
		if (pbit >= 0) bit_out(pbit[0]);
		bit_out(stop);
		// Long gap so the idle check sees a quiet line
		repeat (16) bit_out(1'b1);
	endtask
endmodule // uart_tx_model

`default_nettype wire

/* File: verification/uart_rx_status_checker.sv */
// Port checker for the receive status block
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_status_params.svh"

module uart_rx_status_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Line
	input wire logic rx_serial
);
	// Quiet line long enough that no frame can still be open
	localparam int IDLE_GAP = 250;
	logic [8:0] hi_r;
	logic [8:0] hi_nxt;
	wire logic rd_go = hsel && hready && htrans[1] && !hwrite;

	always_comb hi_nxt = !rx_serial ? 9'h0 : ((hi_r == 9'h1FF) ? hi_r : hi_r + 9'h1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) hi_r <= 9'h0;
		else hi_r <= hi_nxt;
	end

	// ==========
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd(logic [7:0] a);
		rd_go && haddr[7:0] == a;
	endsequence

	a_ready_always: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_rdata_quiet: assert property (!rd_go |=> hrdata == 32'h0)
		else $error("hrdata not zero outside read");
	a_unmapped_zero: assert property (s_rd(8'h18) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_status_width: assert property (s_rd(`OFS_STATUS_CONTROL) |=> hrdata[31:6] == 26'h0)
		else $error("status upper bits set");
	a_idle_flag: assert property (s_rd(`OFS_STATUS_CONTROL) && hi_r >= IDLE_GAP |=> hrdata[4])
		else $error("idle flag low on quiet line");
	a_err_empty: assert property (s_rd(`OFS_STATUS_CONTROL) ##1 !hrdata[0] |-> hrdata[3:2] == 2'h0)
		else $error("error flag with empty buffer");
	a_data_width: assert property (s_rd(`OFS_RX_DATA) |=> hrdata[31:9] == 23'h0)
		else $error("data upper bits set");
endmodule // uart_rx_status_checker

bind uart_rx_status uart_rx_status_checker u_uart_rx_status_checker (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .rx_serial);

`default_nettype wire

/* File: verification/test_uart_rx_status.sv */
// Bench for the receive status block
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_status_params.svh"

module test_uart_rx_status;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	wire logic rx_serial;
	int failures = 0;
	int compares = 0;
	// Parity bit per mode for 0xA5
	int pb [4] = '{-1, 0, 1, -1};

	always #2.5 hclk = ~hclk;

	uart_rx_status u_uart_rx_status (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_serial, .irq);
	uart_tx_model u_uart_tx_model (.hclk, .rx_serial);

	// ==========
	// Bus tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Sampled before the edge: hrdata drops right after it
	task automatic phase(output logic [31:0] d);
		logic r;
		int i;
		i = 0;
		do begin
			@(negedge hclk);
			r = hreadyout;
			d = hrdata;
			@(posedge hclk);
			i++;
		end while (r !== 1'b1 && i < 20);
		if (r !== 1'b1) begin
			failures++;
			print_verdict();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		phase(d);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		phase(d);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		bus(1'b1, a, v, x);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask

	task print_verdict;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge hclk);
		failures++;
		print_verdict();
	end

	// ==========
	// Scenarios
	initial begin
		logic [8:0] d;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`OFS_STATUS_CONTROL, 32'h10);
		rd(`OFS_CONFIG, 32'h0);
		rd(`OFS_BAUD, 32'h10);
		rd(`OFS_IRQ_MASK, 32'h0);
		rd(8'h18, 32'h0);
		// Writing one to a clear overrun flag must not set it
		wr(`OFS_STATUS_CONTROL, 32'h2);
		rd(`OFS_STATUS_CONTROL, 32'h10);
		for (int m = 0; m < 4; m++) begin
			d = (m == 3) ? 9'h1A5 : 9'h0A5;
			wr(`OFS_CONFIG, 32'(m));
			u_uart_tx_model.send(d, (m == 3) ? 9 : 8, pb[m], 1'b1);
			rd(`OFS_STATUS_CONTROL, 32'h11);
			rd(`OFS_RX_DATA, {23'h0, d});
			rd(`OFS_STATUS_CONTROL, 32'h10);
		end
		// Good, bad parity, bad stop queued together
		wr(`OFS_CONFIG, 32'h1);
		u_uart_tx_model.send(9'h03C, 8, 0, 1'b1);
		u_uart_tx_model.send(9'h03C, 8, 1, 1'b1);
		u_uart_tx_model.send(9'h03C, 8, 0, 1'b0);
		rd(`OFS_STATUS_CONTROL, 32'h11);
		rd(`OFS_RX_DATA, 32'h3C);
		rd(`OFS_STATUS_CONTROL, 32'h19);
		rd(`OFS_RX_DATA, 32'h3C);
		rd(`OFS_STATUS_CONTROL, 32'h15);
		rd(`OFS_RX_DATA, 32'h3C);
		rd(`OFS_STATUS_CONTROL, 32'h10);
		wr(`OFS_IRQ_STATUS, 32'h7);
		wr(`OFS_IRQ_MASK, 32'h1);
		wr(`OFS_CONFIG, 32'h0);
		u_uart_tx_model.send(9'h05A, 8, -1, 1'b1);
		chk({31'h0, irq}, 32'h1);
		wr(`OFS_IRQ_STATUS, 32'h1);
		rd(`OFS_RX_DATA, 32'h5A);
		rd(`OFS_IRQ_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(`OFS_IRQ_MASK, 32'h0);
		// Five into four places
		for (int i = 1; i < 6; i++) u_uart_tx_model.send(9'(i), 8, -1, 1'b1);
		chk({31'h0, irq}, 32'h0);
		rd(`OFS_IRQ_STATUS, 32'h3);
		rd(`OFS_STATUS_CONTROL, 32'h13);
		wr(`OFS_STATUS_CONTROL, 32'h2);
		rd(`OFS_RX_DATA, 32'h1);
		rd(`OFS_STATUS_CONTROL, 32'h13);
		wr(`OFS_STATUS_CONTROL, 32'h0);
		rd(`OFS_CONFIG, 32'h0);
		rd(`OFS_STATUS_CONTROL, 32'h10);
		rd(`OFS_RX_DATA, 32'h0);
		wr(`OFS_CONFIG, 32'h3);
		wr(`OFS_STATUS_CONTROL, 32'h20);
		u_uart_tx_model.send(9'h055, 9, -1, 1'b1);
		rd(`OFS_STATUS_CONTROL, 32'h30);
		u_uart_tx_model.send(9'h1C3, 9, -1, 1'b1);
		rd(`OFS_STATUS_CONTROL, 32'h31);
		rd(`OFS_RX_DATA, 32'h1C3);
		wr(`OFS_CONFIG, 32'h0);
		u_uart_tx_model.send(9'h044, 8, -1, 1'b1);
		rd(`OFS_RX_DATA, 32'h44);
		fork
			u_uart_tx_model.send(9'h0FF, 8, -1, 1'b1);
			begin
				repeat (60) @(posedge hclk);
				rd(`OFS_STATUS_CONTROL, 32'h20);
			end
		join
		rd(`OFS_RX_DATA, 32'hFF);
		print_verdict();
	end
endmodule // test_uart_rx_status

`default_nettype wire
